// File: wdc_watchdog.sv
// Purpose: watchdog timer with prescaler, down counter, feed and clock select
// Assumes: register writes are one-cycle strobes, at most one per cycle
// Notes: pclk_tick_i is the peripheral clock as an enable on clk_i
// Functional notes
// - timeout is 2^(5+tap)*(reload+1)+1 ticks
// - oscillator at 400 kHz, select bit chooses
// - clock select applied only at feed
// - switch releases old, engages new, two ticks
// - prescaler restarts right after every feed
// - oscillator not engaged while old clock stopped
// - timer mode copies prescaler and run bits after one tick
// - timer underflow sets flag, interrupt if enabled
// - flag cleared by writing zero, or by a good feed in watchdog mode
// - timer underflow reloads counter, keeps counting
// - new reload reaches counter at feed or at underflow
// - bad feed ignored in timer mode
// - oscillator runs in power-down only if selected
// - peripheral clock source halts in power-down
// - every underflow raises wake-up
// - feed is A5 then 5A, no writes between
// - bad feed resets in watchdog mode
// - 13-bit prescaler tap decrements 8-bit counter
// - underflow resets chip when reset enabled
module wdc_watchdog (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ctrl_wr_i,
   input wire logic reload_wr_i,
   input wire logic feed1_wr_i,
   input wire logic feed2_wr_i,
   input wire logic other_wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic pclk_tick_i,
   input wire logic power_down_i,
   input wire logic wdt_reset_enable_i,
   input wire logic wdt_interrupt_enable_i,
   output logic [7:0] wdt_control_o,
   output logic [7:0] wdt_reload_value_o,
   output logic [7:0] count_o,
   output logic wdt_timeout_flag_o,
   output logic irq_o,
   output logic wakeup_o,
   output logic wdt_reset_o,
   output logic clk_sel_active_o
);
   typedef struct packed {
      wdc_pkg::wdc_feed_e feed;
      logic [2:0] pre;
      logic run;
      logic clk_sel;
      logic [7:0] reload;
      logic [2:0] sh_pre;
      logic sh_run;
      logic sh_sel;
      logic pend_ctrl;
      logic [wdc_pkg::PRESC_W-1:0] presc;
      logic [7:0] count;
      logic uf_pend;
      logic flag;
      logic irq;
      logic wake;
      logic rst;
      logic [wdc_pkg::OSC_DIV_W-1:0] osc_div;
   } wdc_state_s;

   localparam logic [wdc_pkg::OSC_DIV_W-1:0] OSC_LAST =
      wdc_pkg::OSC_DIV_W'(wdc_pkg::OSC_DIV - 1);
   localparam wdc_state_s ST_RST = '{
      feed: wdc_pkg::FEED_IDLE, pre: wdc_pkg::CTL_PRE_RST,
      run: wdc_pkg::CTL_RUN_RST, clk_sel: wdc_pkg::CTL_CLK_SEL_RST,
      reload: wdc_pkg::RELOAD_RST, sh_pre: wdc_pkg::CTL_PRE_RST,
      sh_run: wdc_pkg::CTL_RUN_RST, sh_sel: wdc_pkg::CTL_CLK_SEL_RST,
      pend_ctrl: 1'b0, presc: '0, count: wdc_pkg::RELOAD_RST, uf_pend: 1'b0,
      flag: 1'b0, irq: 1'b0, wake: 1'b0, rst: 1'b0, osc_div: '0};

   wdc_state_s q_reg;
   wdc_state_s q_next;
   logic osc_tick;
   logic pclk_tick;
   logic wd_tick;
   logic any_wr;
   logic feed_ok;
   logic feed_bad;
   logic tap;
   logic underflow;
   logic osc_on;
   logic [wdc_pkg::PRESC_W-1:0] tap_mask;

   assign osc_on = !power_down_i || q_reg.sh_sel;
   assign osc_tick = osc_on && (q_reg.osc_div == OSC_LAST);
   assign pclk_tick = pclk_tick_i && !power_down_i;

   // switch waits on old ticks, so a stopped clock holds it
   wdc_clk_switch wdc_clk_switch_i (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sel_req_i(q_reg.sh_sel),
      .osc_tick_i(osc_tick),
      .pclk_tick_i(pclk_tick),
      .tick_o(wd_tick),
      .sel_active_o(clk_sel_active_o)
   );

   assign any_wr = ctrl_wr_i | reload_wr_i | feed1_wr_i | feed2_wr_i | other_wr_i;

   always_comb begin
      feed_ok = 1'b0;
      feed_bad = 1'b0;
      if (q_reg.feed == wdc_pkg::FEED_ARMED) begin
         if (feed2_wr_i && wdata_i == wdc_pkg::FEED_SECOND_CODE) begin
            feed_ok = 1'b1;
         end else if (any_wr) begin
            feed_bad = 1'b1;
         end
      end else if (feed1_wr_i && wdata_i != wdc_pkg::FEED_FIRST_CODE) begin
         feed_bad = 1'b1;
      end else if (feed2_wr_i) begin
         feed_bad = 1'b1;
      end
   end

   assign tap_mask = wdc_pkg::PRESC_W'((14'h1 << (wdc_pkg::PRESC_BASE + q_reg.sh_pre)) - 14'h1);
   assign tap = wd_tick && q_reg.sh_run && ((q_reg.presc & tap_mask) == tap_mask);
   // extra tick after the last tap
   assign underflow = wd_tick && q_reg.sh_run && q_reg.uf_pend;

   always_comb begin
      q_next = q_reg;
      q_next.irq = 1'b0;
      q_next.wake = 1'b0;
      q_next.osc_div = osc_on ? (osc_tick ? '0 : q_reg.osc_div + 1'b1) : q_reg.osc_div;
      if (feed1_wr_i && wdata_i == wdc_pkg::FEED_FIRST_CODE && !feed_bad) begin
         q_next.feed = wdc_pkg::FEED_ARMED;
      end else if (any_wr) begin
         q_next.feed = wdc_pkg::FEED_IDLE;
      end
      if (ctrl_wr_i) begin
         q_next.pre = wdata_i[wdc_pkg::CTL_PRE_LSB +: wdc_pkg::CTL_PRE_W];
         q_next.run = wdata_i[wdc_pkg::CTL_RUN_BIT];
         q_next.clk_sel = wdata_i[wdc_pkg::CTL_CLK_SEL_BIT];
         q_next.pend_ctrl = !wdt_reset_enable_i;
         if (!wdata_i[wdc_pkg::CTL_FLAG_BIT]) begin
            q_next.flag = 1'b0;
         end
      end
      if (reload_wr_i) begin
         q_next.reload = wdata_i;
      end
      // timer mode copy after one tick
      if (q_reg.pend_ctrl && wd_tick && !wdt_reset_enable_i) begin
         q_next.sh_pre = q_reg.pre;
         q_next.sh_run = q_reg.run;
         q_next.pend_ctrl = 1'b0;
      end
      if (wd_tick && q_reg.sh_run) begin
         q_next.presc = q_reg.presc + 1'b1;
      end
      if (tap) begin
         if (q_reg.count == 8'h00) begin
            q_next.uf_pend = 1'b1;
         end else begin
            q_next.count = q_reg.count - 8'h01;
         end
      end
      if (underflow) begin
         q_next.count = q_reg.reload;
         q_next.presc = '0;
         q_next.uf_pend = 1'b0;
         q_next.wake = 1'b1;
         q_next.flag = 1'b1;
         q_next.irq = wdt_interrupt_enable_i;
      end
      if (wd_tick && !underflow) begin
         q_next.rst = 1'b0;
      end
      if (underflow && wdt_reset_enable_i) begin
         q_next.rst = 1'b1;
      end
      // bad feed resets, ignored in timer mode
      if (feed_bad && wdt_reset_enable_i) begin
         q_next.rst = 1'b1;
      end
      // feed loads counter and shadow, select applied here
      if (feed_ok) begin
         q_next.count = q_reg.reload;
         q_next.sh_pre = q_reg.pre;
         q_next.sh_run = q_reg.run;
         q_next.sh_sel = q_reg.clk_sel;
         q_next.pend_ctrl = 1'b0;
         q_next.uf_pend = 1'b0;
         q_next.presc = '0;
         if (wdt_reset_enable_i && !underflow) begin
            q_next.flag = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_reg <= ST_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   assign wdt_control_o = {q_reg.pre, 2'b00, q_reg.run, q_reg.flag, q_reg.clk_sel};
   assign wdt_reload_value_o = q_reg.reload;
   assign count_o = q_reg.count;
   assign wdt_timeout_flag_o = q_reg.flag;
   assign irq_o = q_reg.irq;
   assign wakeup_o = q_reg.wake;
   assign wdt_reset_o = q_reg.rst;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_flag_set;
      underflow |=> wdt_timeout_flag_o;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on underflow");

   property p_irq;
      underflow && wdt_interrupt_enable_i |=> irq_o ##1 !irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt pulse wrong");

   property p_flag_clear;
      ctrl_wr_i && !wdata_i[wdc_pkg::CTL_FLAG_BIT] && !underflow |=> !wdt_timeout_flag_o;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_reload;
      underflow && !feed_ok |=> count_o == $past(wdt_reload_value_o);
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_feed_load;
      feed_ok |=> count_o == $past(wdt_reload_value_o) && q_reg.presc == '0;
   endproperty
   a_feed_load: assert property (p_feed_load) else $error("feed did not load");

   property p_bad_reset;
      feed_bad && wdt_reset_enable_i |=> wdt_reset_o;
   endproperty
   a_bad_reset: assert property (p_bad_reset) else $error("bad feed gave no reset");

   property p_reset_cause;
      $rose(wdt_reset_o) |-> $past(wdt_reset_enable_i);
   endproperty
   a_reset_cause: assert property (p_reset_cause) else $error("reset in timer mode");

   property p_uf_reset;
      underflow && wdt_reset_enable_i |=> wdt_reset_o;
   endproperty
   a_uf_reset: assert property (p_uf_reset) else $error("underflow gave no reset");

   property p_wake;
      underflow |=> wakeup_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake-up on underflow");

   property p_sel_switch;
      $changed(clk_sel_active_o) |-> $past(q_reg.sh_sel) == clk_sel_active_o;
   endproperty
   a_sel_switch: assert property (p_sel_switch) else $error("clock switched unasked");

   property p_osc_off;
      power_down_i && !q_reg.sh_sel |-> !osc_tick && !pclk_tick && !wd_tick;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("source runs in power-down");

   c_feed: cover property (feed_ok);
   c_timer_uf: cover property (underflow && !wdt_reset_enable_i);
   c_wd_reset: cover property ($rose(wdt_reset_o));
   c_switch: cover property ($changed(clk_sel_active_o));
endmodule

// File: wdc_pkg.sv
// Purpose: shared constants for the watchdog timer block
// Assumes: 100 MHz core clock, one clock domain
// Notes: feed codes, control layout, reset values, timing counts
package wdc_pkg;
   // core clock and on-chip oscillator
   localparam int unsigned CLK_FREQ_KHZ = 100000;
   localparam int unsigned OSC_FREQ_KHZ = 400;
   localparam int unsigned OSC_DIV = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
   localparam int unsigned OSC_DIV_W = 8;
   // feed sequence codes
   localparam logic [7:0] FEED_FIRST_CODE = 8'ha5;
   localparam logic [7:0] FEED_SECOND_CODE = 8'h5a;
   // control register fields
   localparam int unsigned CTL_CLK_SEL_BIT = 0;
   localparam int unsigned CTL_FLAG_BIT = 1;
   localparam int unsigned CTL_RUN_BIT = 2;
   localparam int unsigned CTL_PRE_LSB = 5;
   localparam int unsigned CTL_PRE_W = 3;
   // reset values
   localparam logic [2:0] CTL_PRE_RST = 3'h7;
   localparam logic CTL_RUN_RST = 1'b1;
   localparam logic CTL_CLK_SEL_RST = 1'b1;
   localparam logic [7:0] RELOAD_RST = 8'hff;
   // prescaler and counter geometry
   localparam int unsigned PRESC_W = 13;
   localparam int unsigned PRESC_BASE = 5;
   localparam int unsigned SYNC_CYCLES = 2;
   // clock switch phases, gray along run -> drop -> engage
   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_DROP = 2'b01,
      SW_ENGAGE = 2'b11
   } wdc_sw_e;
   // feed sequence states
   typedef enum logic [1:0] {
      FEED_IDLE = 2'b00,
      FEED_ARMED = 2'b01
   } wdc_feed_e;
endpackage

// File: wdc_clk_switch.sv
// Purpose: glitch-free watchdog clock source switch on tick enables
// Assumes: ticks are one-cycle pulses synchronous to clk_i
// Notes: old source released after two own ticks, new engaged after two
module wdc_clk_switch (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic sel_req_i,
   input wire logic osc_tick_i,
   input wire logic pclk_tick_i,
   output logic tick_o,
   output logic sel_active_o
);
   typedef struct packed {
      wdc_pkg::wdc_sw_e phase;
      logic active;
      logic [1:0] cnt;
   } wdc_sw_s;

   localparam wdc_sw_s SW_RST = '{phase: wdc_pkg::SW_RUN,
                                 active: wdc_pkg::CTL_CLK_SEL_RST, cnt: 2'h0};
   localparam logic [1:0] SYNC_LAST = 2'(wdc_pkg::SYNC_CYCLES - 1);

   wdc_sw_s q_reg;
   wdc_sw_s q_next;
   logic old_tick;
   logic new_tick;

   assign old_tick = q_reg.active ? osc_tick_i : pclk_tick_i;
   assign new_tick = q_reg.active ? pclk_tick_i : osc_tick_i;
   assign tick_o = (q_reg.phase == wdc_pkg::SW_RUN) && old_tick;
   assign sel_active_o = q_reg.active;

   always_comb begin
      q_next = q_reg;
      case (q_reg.phase)
         wdc_pkg::SW_RUN: begin
            if (sel_req_i != q_reg.active) begin
               q_next.phase = wdc_pkg::SW_DROP;
               q_next.cnt = 2'h0;
            end
         end
         wdc_pkg::SW_DROP: begin
            if (old_tick) begin
               q_next.cnt = q_reg.cnt + 2'h1;
               if (q_reg.cnt == SYNC_LAST) begin
                  q_next.phase = wdc_pkg::SW_ENGAGE;
                  q_next.cnt = 2'h0;
               end
            end
         end
         wdc_pkg::SW_ENGAGE: begin
            if (new_tick) begin
               q_next.cnt = q_reg.cnt + 2'h1;
               if (q_reg.cnt == SYNC_LAST) begin
                  q_next.phase = wdc_pkg::SW_RUN;
                  q_next.active = ~q_reg.active;
                  q_next.cnt = 2'h0;
               end
            end
         end
         default: begin
            q_next = SW_RST;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_reg <= SW_RST;
      end else begin
         q_reg <= q_next;
      end
   end
endmodule

// File: wdc_watchdog_bench.sv
// Purpose: self-checking bench for the watchdog timer block
// Assumes: peripheral clock enable on every second core cycle
// Notes: tick counts follow 2^(5+pre)*(reload+1)+1 from a feed
module wdc_watchdog_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] W_CTL = 5'h01;
   localparam logic [4:0] W_RLD = 5'h02;
   localparam logic [4:0] W_F1 = 5'h04;
   localparam logic [4:0] W_F2 = 5'h08;
   localparam logic [4:0] W_OTH = 5'h10;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] wr = 5'h00;
   logic [7:0] wdata_i = 8'h00;
   logic pclk_tick_i = 1'b0;
   logic pclk_en = 1'b0;
   logic power_down_i = 1'b0;
   logic rst_en = 1'b0;
   logic irq_en = 1'b0;
   logic [7:0] ctl;
   logic [7:0] rld;
   logic [7:0] cnt;
   logic flag;
   logic irq;
   logic wake;
   logic wrst;
   logic sel_act;
   logic [7:0] held;
   int errors = 0;
   int checks = 0;
   int ticks;
   int cyc;

   wdc_watchdog wdc_watchdog_i (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .ctrl_wr_i(wr[0]), .reload_wr_i(wr[1]), .feed1_wr_i(wr[2]),
      .feed2_wr_i(wr[3]), .other_wr_i(wr[4]), .wdata_i(wdata_i),
      .pclk_tick_i(pclk_tick_i), .power_down_i(power_down_i),
      .wdt_reset_enable_i(rst_en), .wdt_interrupt_enable_i(irq_en),
      .wdt_control_o(ctl), .wdt_reload_value_o(rld), .count_o(cnt),
      .wdt_timeout_flag_o(flag), .irq_o(irq), .wakeup_o(wake),
      .wdt_reset_o(wrst), .clk_sel_active_o(sel_act)
   );

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // peripheral clock as an enable every second cycle
   always @(posedge clk_i) begin
      #1;
      pclk_tick_i = pclk_en && !pclk_tick_i;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic put(input logic [4:0] sel, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      wr = sel;
      wdata_i = d;
      @(posedge clk_i);
      #1;
      wr = 5'h00;
   endtask

   task automatic feed;
      put(W_F1, wdc_pkg::FEED_FIRST_CODE);
      put(W_F2, wdc_pkg::FEED_SECOND_CODE);
   endtask

   // counts cycles and peripheral ticks up to the wake-up pulse
   task automatic wait_wake(input int limit);
      ticks = 0;
      cyc = 0;
      while (cyc < limit) begin
         @(posedge clk_i);
         if (pclk_tick_i) ticks++;
         cyc++;
         #1;
         if (wake === 1'b1) break;
      end
      check("wake pulse", wake, 1'b1);
   endtask

   task automatic wait_sel(input logic v);
      cyc = 0;
      while (sel_act !== v && cyc < 1000) begin
         idle(1);
         cyc++;
      end
      check("source in use", sel_act, v);
   endtask

   task automatic wait_rst(input logic v);
      cyc = 0;
      while (wrst !== v && cyc < 20) begin
         idle(1);
         cyc++;
      end
      check("chip reset", wrst, v);
   endtask

   task automatic t_reset;
      check("control", ctl, 8'he5);
      check("reload", rld, 8'hff);
      check("count", cnt, 8'hff);
      check("flag", flag, 1'b0);
      check("source", sel_act, 1'b1);
   endtask

   task automatic t_to_pclk;
      pclk_en = 1'b1;
      put(W_CTL, 8'h04);
      check("control", ctl, 8'h04);
      put(W_RLD, 8'h00);
      idle(600);
      check("source before feed", sel_act, 1'b1);
      feed;
      wait_sel(1'b0);
      check("switch time", cyc >= 4 && cyc <= 506, 1'b1);
   endtask

   task automatic t_timeout;
      irq_en = 1'b1;
      feed;
      wait_wake(200);
      check("ticks to timeout", ticks, 33);
      check("irq", irq, 1'b1);
      check("flag", flag, 1'b1);
      check("count reload", cnt, 8'h00);
      check("chip reset", wrst, 1'b0);
      put(W_CTL, 8'h06);
      check("flag kept", flag, 1'b1);
      put(W_CTL, 8'h04);
      check("flag cleared", flag, 1'b0);
      put(W_CTL, 8'h06);
      check("flag not set", flag, 1'b0);
      irq_en = 1'b0;
      wait_wake(200);
      wait_wake(200);
      check("ticks per period", ticks, 33);
      check("irq masked", irq, 1'b0);
      put(W_CTL, 8'h24);
      wait_wake(200);
      wait_wake(200);
      check("ticks at new tap", ticks, 65);
      put(W_CTL, 8'h04);
   endtask

   task automatic t_feeds;
      put(W_RLD, 8'h03);
      check("reload", rld, 8'h03);
      put(W_F1, 8'ha5);
      put(W_F2, 8'h55);
      idle(2);
      check("count after bad feed", cnt, 8'h00);
      check("chip reset", wrst, 1'b0);
      feed;
      check("count after feed", cnt, 8'h03);
   endtask

   task automatic t_watchdog;
      rst_en = 1'b1;
      feed;
      check("flag after feed", flag, 1'b0);
      put(W_F1, wdc_pkg::FEED_FIRST_CODE);
      put(W_OTH, 8'h00);
      wait_rst(1'b1);
      wait_rst(1'b0);
      feed;
      wait_wake(400);
      check("ticks to timeout", ticks, 129);
      check("reset on underflow", wrst, 1'b1);
      rst_en = 1'b0;
      wait_rst(1'b0);
   endtask

   task automatic t_pd_pclk;
      power_down_i = 1'b1;
      held = cnt;
      idle(300);
      check("count in power-down", cnt, held);
      check("no wake", wake, 1'b0);
      power_down_i = 1'b0;
   endtask

   task automatic t_osc;
      put(W_RLD, 8'h00);
      put(W_CTL, 8'h05);
      feed;
      wait_sel(1'b1);
      feed;
      power_down_i = 1'b1;
      wait_wake(9000);
      check("oscillator timeout", cyc >= 8001 && cyc <= 8252, 1'b1);
      power_down_i = 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_reset;
      t_to_pclk;
      t_timeout;
      t_feeds;
      t_watchdog;
      t_pd_pclk;
      t_osc;
      tally_and_finish;
   end

   initial begin
      #300000;
      errors++;
      tally_and_finish;
   end
endmodule
